/* File: hdl/ast_defs.vh */
// Constants for the asynchronous serial transmitter.
// Assumes inclusion by bare name from the design files.
`ifndef AST_DEFS_VH
`define AST_DEFS_VH
`define AST_DIV_W        16
`define AST_DIV_RESET    16'h0000
`define AST_FRAME_W      11
`define AST_CNT_W        4
`define AST_ST_IDLE      2'h0
`define AST_ST_LOAD      2'h1
`define AST_ST_SHIFT     2'h2
`endif

/* File: hdl/ast_baud_gen.v */
// Baud tick divider: one-cycle pulse every limit+1 clocks (divisor, or its low byte when not wide).
// Assumes a single system clock and synchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "ast_defs.vh"
module ast_baud_gen #(
	parameter W = `AST_DIV_W
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire         run,
	input  wire         wide,
	input  wire [W-1:0] divisor,
	output reg          tick
);
	reg  [W-1:0] cnt_reg;
	wire [W-1:0] limit;

	// 8-bit or 16-bit divider
	assign limit = wide ? divisor : {{(W-8){1'b0}}, divisor[7:0]};

	always @(posedge clk) begin
		if (!rst_n || !run) begin
			cnt_reg <= `AST_DIV_RESET;
			tick    <= 1'b0;
		end else if (cnt_reg >= limit) begin
			cnt_reg <= `AST_DIV_RESET;
			tick    <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
			tick    <= 1'b0;
		end
	end
endmodule // ast_baud_gen
`default_nettype wire

/* File: hdl/ast_shifter.v */
// Frame shift register, sends start, data and one stop bit.
// Assumes baud ticks are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
`include "ast_defs.vh"
module ast_shifter #(
	parameter FW = `AST_FRAME_W,
	parameter CW = `AST_CNT_W
) (
	input  wire          clk,
	input  wire          rst_n,
	input  wire          clear,
	input  wire          load,
	input  wire [8:0]    data,
	input  wire          nine,
	input  wire          tick,
	output wire          line,
	output wire          busy,
	output wire          last_done
);
	reg  [FW-1:0] sh_reg;
	reg  [CW-1:0] left_reg;
	wire [FW-1:0] frame;

	// Start 0, data, ninth or stop, stop 1
	assign frame = nine ? {1'b1, data, 1'b0}
		: {2'b11, data[7:0], 1'b0};
	assign line      = busy ? sh_reg[0] : 1'b1;
	assign busy      = (left_reg != {CW{1'b0}});
	assign last_done = tick && (left_reg == {{(CW-1){1'b0}}, 1'b1});

	always @(posedge clk) begin
		if (!rst_n || clear) begin
			sh_reg   <= {FW{1'b1}};
			left_reg <= {CW{1'b0}};
		end else if (load) begin
			sh_reg   <= frame;
			left_reg <= nine ? 4'hB : 4'hA;
		end else if (tick && busy) begin
			sh_reg   <= {1'b1, sh_reg[FW-1:1]};
			left_reg <= left_reg - 1'b1;
		end
	end
endmodule // ast_shifter
`default_nettype wire

/* File: hdl/ast_tx.v */
// Asynchronous serial transmitter top: holding buffer and shifter.
// Assumes software drives control ports and a write strobe.
`timescale 1ns/1ps
`default_nettype none
`include "ast_defs.vh"
module ast_tx (
	input  wire        CLOCK,
	input  wire        RST_N,
	input  wire        TRANSMITTER_ON,
	input  wire        SERIAL_PORT_ON,
	input  wire        CLOCKED_MODE,
	input  wire        NINTH_BIT_SELECT,
	input  wire        NINTH_DATA_BIT,
	input  wire        BAUD_WIDE,
	input  wire [15:0] BAUD_DIVISOR,
	input  wire        TX_BUFFER_WR,
	input  wire [7:0]  TX_BUFFER_DATA,
	input  wire        TX_BUFFER_IRQ_MASK,
	input  wire        GPIO_OUT,
	input  wire        GPIO_OUT_EN_N,
	output reg         SERIAL_OUT_PIN_O,
	output reg         SERIAL_OUT_PIN_OE_N,
	output reg         TX_BUFFER_EMPTY_FLAG,
	output reg         SHIFTER_EMPTY_STATUS,
	output reg         TX_IRQ
);
	reg  [8:0] hold_reg;
	reg  [8:0] stage_reg;
	reg        full_reg;
	reg        load_reg;
	wire       run;
	wire       tick;
	wire       line;
	wire       busy;
	wire       last_done;
	wire       load_now;

	assign run = TRANSMITTER_ON && SERIAL_PORT_ON && !CLOCKED_MODE;
	// Empty shifter takes buffer at once, else after stop bit
	assign load_now = full_reg && !load_reg && (!busy || last_done);

	ast_baud_gen #(.W(`AST_DIV_W)) u_baud (
		.clk     (CLOCK),
		.rst_n   (RST_N),
		.run     (run && (busy || load_reg) && !last_done),
		.wide    (BAUD_WIDE),
		.divisor (BAUD_DIVISOR),
		.tick    (tick)
	);

	ast_shifter u_shift (
		.clk       (CLOCK),
		.rst_n     (RST_N),
		.clear     (!run),
		.load      (load_reg),
		.data      (stage_reg),
		.nine      (NINTH_BIT_SELECT),
		.tick      (tick),
		.line      (line),
		.busy      (busy),
		.last_done (last_done)
	);

	// Holding buffer, ninth bit captured with low byte
	always @(posedge CLOCK) begin
		if (!RST_N || !run) begin
			hold_reg  <= 9'h000;
			stage_reg <= 9'h000;
			full_reg  <= 1'b0;
			load_reg  <= 1'b0;
		end else begin
			load_reg <= load_now;
			// Staged copy keeps a same-cycle write from replacing it
			if (load_now)
				stage_reg <= hold_reg;
			if (TX_BUFFER_WR) begin
				hold_reg <= {NINTH_DATA_BIT, TX_BUFFER_DATA};
				full_reg <= 1'b1;
			end else if (load_now) begin
				full_reg <= 1'b0;
			end
		end
	end

	// Registered outputs
	always @(posedge CLOCK) begin
		if (!RST_N) begin
			SERIAL_OUT_PIN_O     <= 1'b1;
			SERIAL_OUT_PIN_OE_N  <= 1'b1;
			TX_BUFFER_EMPTY_FLAG <= 1'b0;
			SHIFTER_EMPTY_STATUS <= 1'b1;
			TX_IRQ               <= 1'b0;
		end else begin
			SERIAL_OUT_PIN_O <= SERIAL_PORT_ON ? line : GPIO_OUT;
			SERIAL_OUT_PIN_OE_N <= SERIAL_PORT_ON ? 1'b0
				: GPIO_OUT_EN_N;
			TX_BUFFER_EMPTY_FLAG <= run && !full_reg;
			SHIFTER_EMPTY_STATUS <= !busy && !load_reg;
			TX_IRQ <= run && !full_reg && TX_BUFFER_IRQ_MASK;
		end
	end
endmodule // ast_tx
`default_nettype wire

/* File: testbench/ast_tx_sva.sv */
// Port checker for the transmitter.
// Assumes one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module ast_chk (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic TRANSMITTER_ON,
	input wire logic SERIAL_PORT_ON,
	input wire logic CLOCKED_MODE,
	input wire logic TX_BUFFER_WR,
	input wire logic TX_BUFFER_IRQ_MASK,
	input wire logic SERIAL_OUT_PIN_O,
	input wire logic SERIAL_OUT_PIN_OE_N,
	input wire logic TX_BUFFER_EMPTY_FLAG,
	input wire logic SHIFTER_EMPTY_STATUS,
	input wire logic TX_IRQ
);
	wire run = TRANSMITTER_ON & SERIAL_PORT_ON & !CLOCKED_MODE;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	AST_IDLE: assert property (
		SERIAL_PORT_ON ##1 SHIFTER_EMPTY_STATUS |-> SERIAL_OUT_PIN_O)
		else $error("idle");
	AST_PIN: assert property (
		SERIAL_PORT_ON [*2] |-> !SERIAL_OUT_PIN_OE_N) else $error("oe");
	AST_IRQ: assert property (
		(TX_BUFFER_EMPTY_FLAG && TX_BUFFER_IRQ_MASK) [*2] |-> TX_IRQ)
		else $error("irq");
	AST_OFF: assert property (
		!TRANSMITTER_ON [*2] |-> !TX_BUFFER_EMPTY_FLAG) else $error("off");
	AST_ON: assert property (
		$rose(run) |-> ##[0:2] TX_BUFFER_EMPTY_FLAG) else $error("on");
	AST_START: assert property (
		TX_BUFFER_WR && run && SHIFTER_EMPTY_STATUS && TX_BUFFER_EMPTY_FLAG
		|-> ##[3:5] !SERIAL_OUT_PIN_O) else $error("start");
	AST_QUEUE: assert property (
		TX_BUFFER_WR && run && !SHIFTER_EMPTY_STATUS
		|-> ##2 !TX_BUFFER_EMPTY_FLAG) else $error("queue");
	AST_BUSY: assert property (
		$fell(SHIFTER_EMPTY_STATUS) |-> (!SHIFTER_EMPTY_STATUS || !run) [*8])
		else $error("busy");
endmodule // ast_chk
bind ast_tx ast_chk i_chk (.*);
`default_nettype wire

/* File: testbench/ast_rxm.sv */
// Line receiver model.
// Assumes P clocks a bit.
`timescale 1ns/1ps
`default_nettype none
module ast_rxm #(parameter P = 4) (
	input wire logic       clk,
	input wire logic       line,
	input wire logic       nine,
	output var logic [8:0] data,
	output var logic [7:0] n
);
	integer i;
	initial begin
		n = 8'h00;
		forever begin
			@(negedge line);
			data = 9'h000;
			repeat (P / 2) @(posedge clk);
			for (i = 0; i < (nine ? 9 : 8); i++) begin
				repeat (P) @(posedge clk);
				data[i] = line;
			end
			repeat (P) @(posedge clk);
			if (line)
				n = n + 8'h01;
		end
	end
endmodule // ast_rxm
`default_nettype wire

/* File: testbench/tb_async_serial_transmitter.sv */
// Bench for the serial transmitter.
// Assumes the line model ast_rxm.
`timescale 1ns/1ps
`default_nettype none
module tb_async_serial_transmitter;
	logic clk = 0, rst_n = 0, ton = 0, pon = 0, nsel = 0, nbit = 0, wide = 1;
	logic wr = 0, mask = 0, gpo = 1, goen = 1, cmode = 0;
	logic [15:0] div = 16'h0003;
	logic [7:0] dat = 8'h00, nfr;
	logic [8:0] rxd;
	wire pin, oen, flag, semp, irq;
	integer num_errors = 0, n_compared = 0, k;
	ast_tx i_dut (.CLOCK(clk), .RST_N(rst_n), .TRANSMITTER_ON(ton),
		.SERIAL_PORT_ON(pon), .CLOCKED_MODE(cmode), .NINTH_BIT_SELECT(nsel),
		.NINTH_DATA_BIT(nbit), .BAUD_WIDE(wide), .BAUD_DIVISOR(div),
		.TX_BUFFER_WR(wr), .TX_BUFFER_DATA(dat), .TX_BUFFER_IRQ_MASK(mask),
		.GPIO_OUT(gpo), .GPIO_OUT_EN_N(goen), .SERIAL_OUT_PIN_O(pin),
		.SERIAL_OUT_PIN_OE_N(oen), .TX_BUFFER_EMPTY_FLAG(flag),
		.SHIFTER_EMPTY_STATUS(semp), .TX_IRQ(irq));
	ast_rxm i_rx (.clk(clk), .line(pin), .nine(nsel), .data(rxd), .n(nfr));
	task chk(input logic [8:0] got, input logic [8:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task conclude;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task wfr(input logic [7:0] c);
		for (k = 0; nfr < c; k++) begin
			if (k == 600) begin
				num_errors++;
				conclude;
			end
			@(posedge clk);
		end
	endtask
	task send(input logic [8:0] d);
		@(posedge clk);
		nbit <= d[8];
		dat <= d[7:0];
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task t_en;
		@(posedge clk);
		ton <= 1'b1;
		pon <= 1'b1;
		mask <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk({pin, oen, flag, semp, irq}, 9'h017);
	endtask
	task t_frames;
		send(9'h0A5);
		repeat (4) @(posedge clk);
		send(9'h03C);
		repeat (2) @(posedge clk);
		#1 chk(flag, 9'h000);
		chk(semp, 9'h000);
		wfr(8'h01);
		chk(rxd, 9'h0A5);
		wfr(8'h02);
		chk(rxd, 9'h03C);
		nsel <= 1'b1;
		wide <= 1'b0;
		div <= 16'h0103;
		send(9'h15A);
		wfr(8'h03);
		chk(rxd, 9'h15A);
	endtask
	task t_off;
		cmode <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk({flag, semp}, 9'h001);
		@(posedge clk);
		cmode <= 1'b0;
		mask <= 1'b0;
		ton <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk({pin, flag, irq, semp}, 9'h009);
		@(posedge clk);
		pon <= 1'b0;
		gpo <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk({pin, oen}, 9'h001);
	endtask
	initial forever #12.5 clk = ~clk;
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		#1 chk({pin, oen, flag, semp, irq}, 9'h01A);
		t_en;
		t_frames;
		t_off;
		conclude;
	end
endmodule // tb_async_serial_transmitter
`default_nettype wire
